/* shared/inst_exec_pkg.sv */
// Package with opcodes, field layouts and widths for the instruction execute subset
package inst_exec_pkg;
  // Widths
  localparam int DATA_W = 8;   // Data path width
  localparam int FADDR_W = 7;  // File register address width
  localparam int INST_W = 14;  // Instruction word width
  localparam int PC_W = 15;    // Program counter width
  localparam int JUMP_W = 11;  // Absolute jump immediate width
  localparam int LATCH_LO = 3; // Lowest latch-high bit used by the jump
  localparam int LATCH_HI = 6; // Highest latch-high bit used by the jump
  localparam int DEST_BIT = 7; // Destination bit position in file instructions

  // Opcode fields (upper bits of the instruction word)
  localparam logic [13:0] CLEAR_ACC_CODE = 14'h0100;    // Clear accumulator, compared under CLEAR_ACC_MASK
  localparam logic [13:0] CLEAR_ACC_MASK = 14'h3f80;    // Bits compared for clear
  localparam logic [5:0] DEC_SKIP_CODE = 6'h0b;         // Decrement, skip if zero
  localparam logic [5:0] INC_SKIP_CODE = 6'h0f;         // Increment, skip if zero
  localparam logic [5:0] INC_FILE_CODE = 6'h0a;         // Increment file
  localparam logic [5:0] OR_FILE_CODE = 6'h04;          // OR accumulator with file
  localparam logic [5:0] OR_LIT_CODE = 6'h38;           // OR accumulator with literal
  localparam logic [2:0] JUMP_CODE = 3'h5;              // Absolute jump

  // Constants
  localparam logic [7:0] ZERO_BYTE = 8'h00;  // Cleared value
  localparam logic [7:0] ONE_BYTE = 8'h01;   // Increment and decrement step
  localparam logic [7:0] ACC_RESET = 8'h00;  // Accumulator reset value

  // Decoded operation kinds
  typedef enum logic [2:0] {
    OP_NONE, OP_CLEAR_ACC, OP_DEC_SKIP, OP_INC_SKIP, OP_INC_FILE, OP_OR_FILE, OP_OR_LIT,
    OP_JUMP
  } op_e;

  // File write-back request
  typedef struct packed {
    logic we;             // Write strobe
    logic [6:0] addr;     // File address
    logic [7:0] data;     // Write data
  } file_wr_s;

  // Program counter load request
  typedef struct packed {
    logic load;           // Load strobe
    logic [14:0] target;  // New program counter
  } pc_load_s;
endpackage : inst_exec_pkg

/* core/cpu_inst_exec_subset.sv */
// Execute stage for a subset of 8-bit core instructions
`timescale 1ns/100ps
module cpu_inst_exec_subset (
  input wire logic SYS_CLK_I,                 // Core instruction clock, 250 MHz
  input wire logic SYS_RST_I,                 // Synchronous reset, active high
  input wire logic INST_VALID_I,              // Fetched instruction valid this cycle
  input wire logic [13:0] INST_WORD_I,        // Fetched instruction word
  input wire logic [7:0] FILE_RDATA_I,        // Addressed file register contents
  input wire logic [7:0] LATCH_HIGH_I,        // Program counter latch-high register
  output logic [6:0] FILE_RADDR_O,            // File read address (registered copy)
  output inst_exec_pkg::file_wr_s FILE_WR_O,  // File write-back request
  output inst_exec_pkg::pc_load_s PC_LOAD_O,  // Program counter load request
  output logic [7:0] ACC_O,                   // Working accumulator
  output logic ZERO_FLAG_O,                   // Zero status flag
  output logic SQUASH_O,                      // Current slot executes as no-operation
  output logic BUSY_O                         // Second cycle of a two-cycle instruction
);

  ////////////////////////////////////////////////////////////////////////////////////
  // Decode

  inst_exec_pkg::op_e op;          // Decoded operation
  logic [7:0] acc_r;               // Accumulator
  logic [7:0] acc_nxt;             // Next accumulator
  logic zero_r;                    // Zero flag
  logic zero_nxt;                  // Next zero flag
  logic [7:0] result;              // Operation result
  logic dest_file;                 // Destination bit
  logic skip_nxt;                  // Squash the following slot
  logic skip_r;                    // Squash in effect for current slot
  logic jump_r;                    // Jump second cycle
  logic live;                      // Instruction actually executes
  logic [6:0] faddr;               // File address field

  // Classify an instruction word
  function automatic inst_exec_pkg::op_e decode_op(input logic [13:0] w);
    if ((w & inst_exec_pkg::CLEAR_ACC_MASK) == inst_exec_pkg::CLEAR_ACC_CODE) begin
      return inst_exec_pkg::OP_CLEAR_ACC;
    end
    if (w[13:11] == inst_exec_pkg::JUMP_CODE) begin
      return inst_exec_pkg::OP_JUMP;
    end
    unique case (w[13:8])
      inst_exec_pkg::DEC_SKIP_CODE: return inst_exec_pkg::OP_DEC_SKIP;
      inst_exec_pkg::INC_SKIP_CODE: return inst_exec_pkg::OP_INC_SKIP;
      inst_exec_pkg::INC_FILE_CODE: return inst_exec_pkg::OP_INC_FILE;
      inst_exec_pkg::OR_FILE_CODE: return inst_exec_pkg::OP_OR_FILE;
      inst_exec_pkg::OR_LIT_CODE: return inst_exec_pkg::OP_OR_LIT;
      default: return inst_exec_pkg::OP_NONE;
    endcase
  endfunction : decode_op

  // Zero test shared by the skip paths and every flag-writing path except clear
  function automatic logic is_zero(input logic [7:0] v);
    return v == inst_exec_pkg::ZERO_BYTE;
  endfunction : is_zero

  // Live only when valid, not squashed and not in a jump's second cycle
  assign live = INST_VALID_I && !skip_r && !jump_r;
  assign op = live ? decode_op(INST_WORD_I) : inst_exec_pkg::OP_NONE;
  assign dest_file = INST_WORD_I[inst_exec_pkg::DEST_BIT];
  assign faddr = INST_WORD_I[inst_exec_pkg::FADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////////
  // Execute

  // Result, accumulator, flag and skip selection
  always_comb begin
    result = inst_exec_pkg::ZERO_BYTE;
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    skip_nxt = 1'b0;
    unique case (op)
      inst_exec_pkg::OP_CLEAR_ACC: begin
        acc_nxt = inst_exec_pkg::ZERO_BYTE;
        zero_nxt = 1'b1;
      end
      inst_exec_pkg::OP_DEC_SKIP: begin
        result = FILE_RDATA_I - inst_exec_pkg::ONE_BYTE;
        skip_nxt = is_zero(result);
      end
      inst_exec_pkg::OP_INC_SKIP: begin
        result = FILE_RDATA_I + inst_exec_pkg::ONE_BYTE;
        skip_nxt = is_zero(result);
      end
      inst_exec_pkg::OP_INC_FILE: begin
        result = FILE_RDATA_I + inst_exec_pkg::ONE_BYTE;
        zero_nxt = is_zero(result);
      end
      inst_exec_pkg::OP_OR_FILE: begin
        result = acc_r | FILE_RDATA_I;
        zero_nxt = is_zero(result);
      end
      inst_exec_pkg::OP_OR_LIT: begin
        result = acc_r | INST_WORD_I[inst_exec_pkg::DATA_W-1:0];
        acc_nxt = result;
        zero_nxt = is_zero(result);
      end
      default: begin
        result = inst_exec_pkg::ZERO_BYTE; // Jump and idle leave data alone
      end
    endcase
    // Route file-operand results by the destination bit
    if (op == inst_exec_pkg::OP_DEC_SKIP || op == inst_exec_pkg::OP_INC_SKIP ||
        op == inst_exec_pkg::OP_INC_FILE || op == inst_exec_pkg::OP_OR_FILE) begin
      if (!dest_file) begin
        acc_nxt = result;
      end
    end
  end

  // Accumulator and zero flag
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      acc_r <= inst_exec_pkg::ACC_RESET;
      zero_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end

  // File write-back strobe
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      FILE_WR_O <= '0;
    end else begin
      FILE_WR_O.we <= dest_file && (op == inst_exec_pkg::OP_DEC_SKIP ||
        op == inst_exec_pkg::OP_INC_SKIP || op == inst_exec_pkg::OP_INC_FILE ||
        op == inst_exec_pkg::OP_OR_FILE);
      FILE_WR_O.addr <= faddr;
      FILE_WR_O.data <= result;
    end
  end

  // Registered copy of the file address for observation
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      FILE_RADDR_O <= '0;
    end else begin
      FILE_RADDR_O <= faddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // Skip and jump sequencing

  // Skip squashes exactly the next valid slot
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      skip_r <= 1'b0;
    end else if (skip_nxt) begin
      skip_r <= 1'b1;
    end else if (INST_VALID_I) begin
      skip_r <= 1'b0;
    end
  end

  // Jump second cycle and program counter load
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      jump_r <= 1'b0;
      PC_LOAD_O <= '0;
    end else begin
      jump_r <= (op == inst_exec_pkg::OP_JUMP);
      PC_LOAD_O.load <= (op == inst_exec_pkg::OP_JUMP);
      PC_LOAD_O.target <= {LATCH_HIGH_I[inst_exec_pkg::LATCH_HI:inst_exec_pkg::LATCH_LO],
        INST_WORD_I[inst_exec_pkg::JUMP_W-1:0]};
    end
  end

  // Status outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      SQUASH_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      SQUASH_O <= skip_nxt || (skip_r && !INST_VALID_I);
      BUSY_O <= (op == inst_exec_pkg::OP_JUMP);
    end
  end

  assign ACC_O = acc_r;
  assign ZERO_FLAG_O = zero_r;

  ////////////////////////////////////////////////////////////////////////////////////
  // Checks

  clear_acc_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_CLEAR_ACC |=> (ACC_O == 8'h00 && ZERO_FLAG_O))
    else $error("clear did not zero accumulator and set flag");
  dest_route_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_INC_FILE && !dest_file) |=> (!FILE_WR_O.we && ACC_O == $past(result)))
    else $error("destination zero did not go to accumulator");
  dec_flags_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_DEC_SKIP |=> $stable(ZERO_FLAG_O))
    else $error("decrement-skip changed zero flag");
  dec_skip_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_DEC_SKIP && FILE_RDATA_I == 8'h01) |=> (skip_r && op == inst_exec_pkg::OP_NONE))
    else $error("zero decrement did not squash next slot");
  inc_skip_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_INC_SKIP && FILE_RDATA_I != 8'hff) |=> !skip_r)
    else $error("nonzero increment squashed next slot");
  jump_target_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_JUMP |=> (PC_LOAD_O.load &&
      PC_LOAD_O.target[10:0] == $past(INST_WORD_I[10:0]) &&
      PC_LOAD_O.target[14:11] == $past(LATCH_HIGH_I[6:3])))
    else $error("jump target wrong");
  jump_cycles_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_JUMP |=> (op == inst_exec_pkg::OP_NONE && $stable(ZERO_FLAG_O)))
    else $error("jump second cycle not idle");
  or_lit_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_OR_LIT |=> ACC_O == ($past(acc_r) | $past(INST_WORD_I[7:0])))
    else $error("literal OR wrong");
  inc_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_INC_FILE && FILE_RDATA_I == 8'hff) |=> ZERO_FLAG_O)
    else $error("increment wrap did not set zero");
  or_file_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_OR_FILE && dest_file) |=>
      (FILE_WR_O.we && ZERO_FLAG_O == (FILE_WR_O.data == 8'h00)))
    else $error("file OR write-back or flag wrong");

  // Skip request shows as a squashed slot next cycle
  squash_out_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    skip_nxt |=> SQUASH_O)
    else $error("skip did not raise squash");

  // Nonzero decrement leaves the next slot live
  dec_noskip_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_DEC_SKIP && FILE_RDATA_I != 8'h01) |=> !skip_r)
    else $error("nonzero decrement squashed next slot");

  // Decrement-skip writes the wrapped value back
  dec_value_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_DEC_SKIP && dest_file) |=>
      (FILE_WR_O.we && FILE_WR_O.data == $past(FILE_RDATA_I) - 8'h01))
    else $error("decrement-skip value wrong");

  // Increment-skip leaves the zero flag alone
  inc_skip_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_INC_SKIP |=> $stable(ZERO_FLAG_O))
    else $error("increment-skip changed zero flag");

  // Plain increment writes the wrapped value back
  inc_value_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_INC_FILE && dest_file) |=>
      (FILE_WR_O.we && FILE_WR_O.data == $past(FILE_RDATA_I) + 8'h01))
    else $error("increment value wrong");

  // Literal OR sets the flag from the new accumulator
  or_lit_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_OR_LIT |=> ZERO_FLAG_O == (ACC_O == 8'h00))
    else $error("literal OR flag wrong");

  // File destination leaves the accumulator alone
  dest_acc_keep_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_OR_FILE && dest_file) |=> $stable(ACC_O))
    else $error("file destination touched accumulator");

  // File OR into the accumulator
  or_file_acc_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (op == inst_exec_pkg::OP_OR_FILE && !dest_file) |=>
      ACC_O == ($past(acc_r) | $past(FILE_RDATA_I)))
    else $error("file OR into accumulator wrong");

  // Clear never writes a file register
  clear_only_acc_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_CLEAR_ACC |=> !FILE_WR_O.we)
    else $error("clear wrote a file register");

  // Jump raises busy for its second cycle
  busy_out_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_JUMP |=> BUSY_O)
    else $error("jump did not raise busy");

  // Busy lasts exactly one cycle
  busy_drop_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    BUSY_O |=> !BUSY_O)
    else $error("busy held too long");

  // Counter load is a single pulse
  load_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    PC_LOAD_O.load |=> !PC_LOAD_O.load)
    else $error("counter load held too long");

  // Jump leaves the accumulator alone
  jump_acc_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    op == inst_exec_pkg::OP_JUMP |=> $stable(ACC_O))
    else $error("jump changed accumulator");

endmodule : cpu_inst_exec_subset

/* tb/file_reg_model.sv */
// File register model answering reads and write-backs of the execute stage
`timescale 1ns/100ps
module file_reg_model (
  input wire logic clk_i,                  // Core clock
  input wire logic [6:0] raddr_i,          // Read address from the instruction word
  input wire inst_exec_pkg::file_wr_s wr_i, // Write-back from the execute stage
  input wire logic seed_we_i,              // Bench preload strobe
  input wire logic [6:0] seed_addr_i,      // Bench preload address
  input wire logic [7:0] seed_data_i,      // Bench preload data
  output logic [7:0] rdata_o               // Read data, same cycle
);
  logic [7:0] mem_r [128]; // Register contents
  // Combinational read, as the core register file answers
  assign rdata_o = mem_r[raddr_i];
  // Write-back from the stage and preload from the bench
  always_ff @(posedge clk_i) begin
    if (wr_i.we) begin
      mem_r[wr_i.addr] <= wr_i.data;
    end
    if (seed_we_i) begin
      mem_r[seed_addr_i] <= seed_data_i;
    end
  end
endmodule : file_reg_model

/* tb/cpu_inst_exec_subset_test.sv */
// Self-checking bench for the instruction execute subset
`timescale 1ns/100ps
module cpu_inst_exec_subset_test;
  logic SYS_CLK_I = 1'b0; // Core clock
  logic SYS_RST_I = 1'b1; // Reset, held at start
  logic INST_VALID_I = 1'b0; // Instruction valid
  logic [13:0] INST_WORD_I = 14'h0000; // Instruction word
  logic [7:0] LATCH_HIGH_I = 8'h00; // Latch-high register
  logic [7:0] FILE_RDATA_I; // From the file model
  logic [6:0] FILE_RADDR_O; // Registered copy of the address, checked once
  inst_exec_pkg::file_wr_s FILE_WR_O; // Write-back
  inst_exec_pkg::pc_load_s PC_LOAD_O; // Counter load
  logic [7:0] ACC_O; // Accumulator
  logic ZERO_FLAG_O; // Zero flag
  logic SQUASH_O; // Slot squashed
  logic BUSY_O; // Jump second cycle
  logic seed_we = 1'b0; // Preload strobe
  logic [6:0] seed_addr = 7'h00; // Preload address
  logic [7:0] seed_data = 8'h00; // Preload data
  int fails = 0; // Mismatches
  int comparisons = 0; // Checks made
  cpu_inst_exec_subset dut_u (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
    .INST_VALID_I(INST_VALID_I), .INST_WORD_I(INST_WORD_I), .FILE_RDATA_I(FILE_RDATA_I),
    .LATCH_HIGH_I(LATCH_HIGH_I), .FILE_RADDR_O(FILE_RADDR_O), .FILE_WR_O(FILE_WR_O),
    .PC_LOAD_O(PC_LOAD_O), .ACC_O(ACC_O), .ZERO_FLAG_O(ZERO_FLAG_O), .SQUASH_O(SQUASH_O),
    .BUSY_O(BUSY_O));
  file_reg_model file_u (.clk_i(SYS_CLK_I), .raddr_i(INST_WORD_I[6:0]), .wr_i(FILE_WR_O),
    .seed_we_i(seed_we), .seed_addr_i(seed_addr), .seed_data_i(seed_data),
    .rdata_o(FILE_RDATA_I));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial begin
    forever begin
      #2;
      SYS_CLK_I = ~SYS_CLK_I;
    end
  end
  // Verdict and end of run
  task report_and_stop;
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // Compare seen against expected
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // One slot at the rising edge; outputs settle before return
  task step(input logic v, input logic [13:0] w);
    @(posedge SYS_CLK_I);
    INST_VALID_I <= v;
    INST_WORD_I <= w;
    seed_we <= 1'b0;
    #1;
  endtask : step
  // Single instruction, results visible on return
  task run(input logic [13:0] w);
    step(1'b1, w);
    step(1'b0, w);
  endtask : run
  // Instruction followed back to back by a literal OR of all ones
  task pair(input logic [13:0] w);
    step(1'b1, w);
    step(1'b1, {inst_exec_pkg::OR_LIT_CODE, 8'hff});
  endtask : pair
  // Preload one file register
  task seed(input logic [6:0] a, input logic [7:0] d);
    @(posedge SYS_CLK_I);
    seed_we <= 1'b1;
    seed_addr <= a;
    seed_data <= d;
    #1;
  endtask : seed
  // File instruction word
  function automatic logic [13:0] fw(logic [5:0] c, logic d, logic [6:0] f);
    return {c, d, f};
  endfunction : fw
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (1000) @(posedge SYS_CLK_I);
    fails++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge SYS_CLK_I);
    SYS_RST_I <= 1'b0;
    #1;
    chk("acc", ACC_O, 8'h00);
    run({inst_exec_pkg::OR_LIT_CODE, 8'h5a});
    chk("acc", ACC_O, 8'h5a);
    chk("zero", ZERO_FLAG_O, 1'b0);
    run(inst_exec_pkg::CLEAR_ACC_CODE);
    chk("acc", ACC_O, 8'h00);
    chk("zero", ZERO_FLAG_O, 1'b1);
    seed(7'h05, 8'hff);
    seed(7'h06, 8'h10);
    seed(7'h07, 8'h01);
    seed(7'h08, 8'ha0);
    seed(7'h09, 8'h00);
    run({inst_exec_pkg::OR_LIT_CODE, 8'h5a});
    run(fw(inst_exec_pkg::INC_FILE_CODE, 1'b0, 7'h05));
    chk("acc", ACC_O, 8'h00);
    chk("zero", ZERO_FLAG_O, 1'b1);
    chk("wr", FILE_WR_O, {1'b0, 7'h05, 8'h00});
    run(fw(inst_exec_pkg::INC_FILE_CODE, 1'b1, 7'h06));
    chk("wr", FILE_WR_O, {1'b1, 7'h06, 8'h11});
    chk("zero", ZERO_FLAG_O, 1'b0);
    pair(fw(inst_exec_pkg::INC_SKIP_CODE, 1'b1, 7'h05));
    chk("wr", FILE_WR_O, {1'b1, 7'h05, 8'h00});
    chk("squash", SQUASH_O, 1'b1);
    chk("zero", ZERO_FLAG_O, 1'b0);
    step(1'b0, 14'h0000);
    chk("acc", ACC_O, 8'h00);
    pair(fw(inst_exec_pkg::DEC_SKIP_CODE, 1'b0, 7'h07));
    chk("squash", SQUASH_O, 1'b1);
    chk("zero", ZERO_FLAG_O, 1'b0);
    step(1'b0, 14'h0000);
    chk("acc", ACC_O, 8'h00);
    pair(fw(inst_exec_pkg::DEC_SKIP_CODE, 1'b1, 7'h08));
    chk("wr", FILE_WR_O, {1'b1, 7'h08, 8'h9f});
    chk("squash", SQUASH_O, 1'b0);
    step(1'b0, 14'h0000);
    chk("acc", ACC_O, 8'hff);
    run(inst_exec_pkg::CLEAR_ACC_CODE);
    pair(fw(inst_exec_pkg::DEC_SKIP_CODE, 1'b0, 7'h09));
    chk("acc", ACC_O, 8'hff);
    chk("zero", ZERO_FLAG_O, 1'b1);
    run(inst_exec_pkg::CLEAR_ACC_CODE);
    run({inst_exec_pkg::OR_LIT_CODE, 8'h0f});
    run(fw(inst_exec_pkg::OR_FILE_CODE, 1'b1, 7'h08));
    chk("wr", FILE_WR_O, {1'b1, 7'h08, 8'h9f});
    chk("acc", ACC_O, 8'h0f);
    run(fw(inst_exec_pkg::OR_FILE_CODE, 1'b0, 7'h09));
    chk("acc", ACC_O, 8'h0f);
    run(inst_exec_pkg::CLEAR_ACC_CODE);
    run(fw(inst_exec_pkg::OR_FILE_CODE, 1'b0, 7'h09));
    chk("zero", ZERO_FLAG_O, 1'b1);
    chk("raddr", FILE_RADDR_O, 7'h09);
    @(posedge SYS_CLK_I);
    LATCH_HIGH_I <= 8'h5b;
    pair({inst_exec_pkg::JUMP_CODE, 11'h7ff});
    chk("pc", PC_LOAD_O, {1'b1, 4'hb, 11'h7ff});
    chk("busy", BUSY_O, 1'b1);
    chk("zero", ZERO_FLAG_O, 1'b1);
    step(1'b0, 14'h0000);
    chk("acc", ACC_O, 8'h00);
    chk("load", PC_LOAD_O.load, 1'b0);
    report_and_stop();
  end
endmodule : cpu_inst_exec_subset_test
